// file: design/flex_pack_acquisition_config.sv
// acquisition sequencer, flex-pack supply mux control, trim rom and identifier
`timescale 1ns/10ps
`include "flex_pack_map.svh"
module flex_pack_acquisition_config #(
   parameter logic [15:0] TRIM_WORD [0:10] = '{default: 16'h0000}, // arbitrary
   parameter logic [7:0] TRIM_CRC = 8'h00, // arbitrary
   parameter logic [31:0] DEVICE_ID = 32'h0000_0001 // arbitrary
) (
   input wire logic clk,
   input wire logic rst,
   input wire flex_pack_pkg::pack_cfg_t pack_configuration_register,
   input wire logic [13:0] cellChannelEnables,
   input wire logic inputPathSelect,
   input wire logic [2:0] oversampleLog2,
   input wire logic acqStart,
   input wire logic [11:0] adcCode,
   input wire logic switchFaultRaw,
   input wire logic alertResetFlag,
   input wire logic [3:0] readIndex,
   output logic [15:0] readData,
   output logic [15:0] trimData,
   output logic [15:0] identifierLowWord,
   output logic [15:0] identifierHighWord,
   output logic [3:0] topCellApplied,
   output logic flexEnableApplied,
   output logic [3:0] blockSourceApplied,
   output logic blockMuxConnect,
   output logic topCellDisconnect,
   output logic [3:0] convChannel,
   output logic convStrobe,
   output logic altPathActive,
   output logic acqBusy,
   output logic acqDone,
   output logic supplyMuxFaultAlert
);
   flex_pack_pkg::acq_state_t state_r;
   logic [15:0] result_r [0:13];
   logic [19:0] accum_r [0:13];
   logic [3:0] chan_r;
   logic scan_r;
   logic [7:0] meas_r;
   logic [9:0] wait_r;
   logic [3:0] topNxt;
   logic enNxt;
   logic [3:0] blkNxt;
   logic copiesMatch;
   logic lastChan;
   logic [3:0] nextChan;
   logic gate_r;

   // copies must agree, else fall back to power-on defaults
   assign copiesMatch = (pack_configuration_register.flexSupplyEnableA == pack_configuration_register.flexSupplyEnableB)
      && (pack_configuration_register.topCellSelectA == pack_configuration_register.topCellSelectB);
   always_comb
   begin
      topNxt = `TOPSEL_OFF;
      enNxt = 1'b1;
      blkNxt = `TOPSEL_OFF;
      if (copiesMatch)
      begin
         enNxt = pack_configuration_register.flexSupplyEnableA;
         if (pack_configuration_register.topCellSelectA >= `TOPSEL_MIN_VALID)
            topNxt = pack_configuration_register.topCellSelectA;
      end
      if (pack_configuration_register.blockDividerSourceSelect >= `TOPSEL_MIN_VALID)
         blkNxt = pack_configuration_register.blockDividerSourceSelect;
   end

   // applied supply mux state; reset restores enabled / off
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         flexEnableApplied <= 1'b1;
         topCellApplied <= `TOPSEL_OFF;
         blockSourceApplied <= `TOPSEL_OFF;
         blockMuxConnect <= 1'b0;
      end
      else
      begin
         flexEnableApplied <= enNxt;
         topCellApplied <= topNxt;
         blockSourceApplied <= blkNxt;
         // only a defined top cell with enable lets the block mux pick a cell
         blockMuxConnect <= enNxt && (topNxt != `TOPSEL_OFF)
            && (blkNxt != `TOPSEL_OFF);
      end
   end

   // next enabled channel after the current one
   always_comb
   begin
      nextChan = 4'h0;
      lastChan = 1'b1;
      for (int i = `CELL_COUNT - 1; i >= 0; i--)
      begin
         if (cellChannelEnables[i] && (4'(i) > chan_r))
         begin
            nextChan = 4'(i);
            lastChan = 1'b0;
         end
      end
   end

   function automatic logic [3:0] first_enabled(input logic [13:0] en);
      logic [3:0] f;
      f = 4'h0;
      for (int i = `CELL_COUNT - 1; i >= 0; i--)
         if (en[i])
            f = 4'(i);
      return f;
   endfunction : first_enabled

   // top cell sits at channel index topCell-1 (cell n = Cn - Cn-1)
   function automatic logic is_top(input logic [3:0] c, input logic [3:0] t);
      return (t != `TOPSEL_OFF) && (c == 4'(t - 4'h1));
   endfunction : is_top

   // sequencer: conversions per scan, two scans per measurement, oversampled
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r <= flex_pack_pkg::S_IDLE;
         chan_r <= 4'h0;
         scan_r <= 1'b0;
         meas_r <= 8'h00;
         wait_r <= 10'h000;
         convStrobe <= 1'b0;
         acqDone <= 1'b0;
         acqBusy <= 1'b0;
         altPathActive <= 1'b0;
         topCellDisconnect <= 1'b0;
      end
      else
      begin
         convStrobe <= 1'b0;
         acqDone <= 1'b0;
         unique case (state_r)
            flex_pack_pkg::S_IDLE:
            begin
               if (acqStart && (cellChannelEnables != 14'h0000))
               begin
                  altPathActive <= inputPathSelect;
                  acqBusy <= 1'b1;
                  chan_r <= first_enabled(cellChannelEnables);
                  scan_r <= 1'b0;
                  meas_r <= 8'h00;
                  wait_r <= 10'h000;
                  state_r <= flex_pack_pkg::S_SETTLE;
               end
            end
            flex_pack_pkg::S_SETTLE:
            begin
               // disconnect only on the alternate path, the sole user of it
               if (altPathActive && flexEnableApplied && pack_configuration_register.flexScanDisconnect
                   && is_top(chan_r, topCellApplied)
                   && (wait_r != 10'(`SETTLE_CYCLES)))
               begin
                  topCellDisconnect <= 1'b1;
                  wait_r <= wait_r + 10'h001;
               end
               else
               begin
                  wait_r <= 10'h000;
                  state_r <= flex_pack_pkg::S_CONV;
               end
            end
            flex_pack_pkg::S_CONV:
            begin
               convStrobe <= 1'b1;
               state_r <= flex_pack_pkg::S_NEXT;
            end
            flex_pack_pkg::S_NEXT:
            begin
               topCellDisconnect <= 1'b0;
               if (!lastChan)
               begin
                  chan_r <= nextChan;
                  state_r <= flex_pack_pkg::S_SETTLE;
               end
               else
               begin
                  chan_r <= first_enabled(cellChannelEnables);
                  scan_r <= ~scan_r;
                  if (scan_r)
                     meas_r <= meas_r + 8'h01;
                  if (scan_r && (meas_r == 8'((9'h001 << oversampleLog2) - 9'h001)))
                     state_r <= flex_pack_pkg::S_STORE;
                  else
                     state_r <= flex_pack_pkg::S_SETTLE;
               end
            end
            flex_pack_pkg::S_STORE:
            begin
               acqBusy <= 1'b0;
               acqDone <= 1'b1;
               state_r <= flex_pack_pkg::S_IDLE;
            end
            default:
               state_r <= flex_pack_pkg::S_IDLE;
         endcase
      end
   end

   assign convChannel = chan_r;

   // per-channel accumulator and left-justified result
   generate
      for (genvar g = 0; g < `CELL_COUNT; g++)
      begin : g_chan
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               accum_r[g] <= 20'h00000;
               result_r[g] <= 16'h0000;
            end
            else if (acqStart && state_r == flex_pack_pkg::S_IDLE)
               accum_r[g] <= 20'h00000;
            else if (convStrobe && chan_r == 4'(g))
               accum_r[g] <= accum_r[g] + {8'h00, adcCode};
            else if (state_r == flex_pack_pkg::S_STORE && cellChannelEnables[g])
               // 2*2^k sums of 12 bits; a spare bit keeps the doubling from wrapping at 128
               result_r[g] <= {14'((21'(accum_r[g]) << 1) >> oversampleLog2), 2'b00};
         end
      end
   endgenerate

   // alert held low until alert reset flag is cleared after power-up
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         gate_r <= 1'b1;
         supplyMuxFaultAlert <= 1'b0;
      end
      else
      begin
         if (!alertResetFlag)
            gate_r <= 1'b0;
         supplyMuxFaultAlert <= !gate_r && flexEnableApplied && switchFaultRaw;
      end
   end

   // 16-bit register reads: results, trim rom, identifier
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         readData <= 16'h0000;
         trimData <= 16'h0000;
         identifierLowWord <= 16'h0000;
         identifierHighWord <= 16'h0000;
      end
      else
      begin
         readData <= (readIndex < 4'(`CELL_COUNT)) ? result_r[readIndex] : 16'h0000;
         if (readIndex == 4'(`TRIM_COUNT - 1))
            trimData <= {TRIM_CRC, TRIM_WORD[`TRIM_COUNT - 1][`CRC_LO - 1:0]};
         else if (readIndex < 4'(`TRIM_COUNT))
            trimData <= TRIM_WORD[readIndex];
         else
            trimData <= 16'h0000;
         identifierLowWord <= DEVICE_ID[15:0];
         identifierHighWord <= DEVICE_ID[31:16];
      end
   end

   // checks
   a_mismatch_defaults: assert property (@(posedge clk) disable iff (rst)
      !copiesMatch |=> flexEnableApplied && topCellApplied == `TOPSEL_OFF)
      else $error("mismatched copies did not apply defaults");
   a_block_mux_gate: assert property (@(posedge clk) disable iff (rst)
      blockMuxConnect |-> flexEnableApplied && topCellApplied != `TOPSEL_OFF)
      else $error("block mux connected without defined top cell");
   a_block_code_map: assert property (@(posedge clk) disable iff (rst)
      blockSourceApplied == `TOPSEL_OFF || blockSourceApplied >= `TOPSEL_MIN_VALID)
      else $error("unsupported block source applied");
   a_topcell_map: assert property (@(posedge clk) disable iff (rst)
      topCellApplied == `TOPSEL_OFF || topCellApplied >= `TOPSEL_MIN_VALID)
      else $error("unsupported top cell applied");
   a_reset_enable: assert property (@(posedge clk)
      rst |=> flexEnableApplied && !supplyMuxFaultAlert)
      else $error("reset did not restore enable");
   a_alert_gating: assert property (@(posedge clk) disable iff (rst)
      supplyMuxFaultAlert |-> $past(switchFaultRaw) && !gate_r)
      else $error("alert raised while gated or without fault");
   a_result_justify: assert property (@(posedge clk) disable iff (rst)
      readData[1:0] == 2'b00)
      else $error("result low bits not zero");
   a_disabled_hold: assert property (@(posedge clk) disable iff (rst)
      (state_r == flex_pack_pkg::S_STORE && !cellChannelEnables[0])
      |=> $stable(result_r[0]))
      else $error("disabled channel result changed");
   a_skip_disabled: assert property (@(posedge clk) disable iff (rst)
      convStrobe |-> cellChannelEnables[chan_r])
      else $error("conversion on disabled channel");
   a_settle_wait: assert property (@(posedge clk) disable iff (rst)
      $rose(topCellDisconnect) |-> !convStrobe [*8])
      else $error("top cell converted before settling");
   a_path_hold: assert property (@(posedge clk) disable iff (rst)
      acqBusy && $past(acqBusy) |-> $stable(altPathActive))
      else $error("path changed during acquisition");
endmodule : flex_pack_acquisition_config

// file: design/flex_pack_map.svh
// channel and trim counts, field positions, reset values and timing counts of the acquisition block
`ifndef FLEX_PACK_MAP_SVH
`define FLEX_PACK_MAP_SVH
`define CELL_COUNT 14
`define TRIM_COUNT 11
`define TOPSEL_OFF 4'hf
`define TOPSEL_MIN_VALID 4'h8
`define CRC_HI 15
`define CRC_LO 8
`define SETTLE_TIME_NS 30000
`define CLK_PERIOD_NS 40
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYCLES 4
`endif

// file: design/flex_pack_pkg.sv
// types shared by the acquisition block
package flex_pack_pkg;
   typedef struct packed {
      logic flexSupplyEnableA;
      logic flexSupplyEnableB;
      logic [3:0] topCellSelectA;
      logic [3:0] topCellSelectB;
      logic [3:0] blockDividerSourceSelect;
      logic flexScanDisconnect;
   } pack_cfg_t;
   typedef struct packed {
      logic [3:0] channel;
      logic [11:0] code;
   } conv_t;
   typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_CONV, S_NEXT, S_STORE} acq_state_t;
endpackage : flex_pack_pkg

// file: tb/adc_source_model.sv
// conversion source standing in for the sampled cell front end
`timescale 1ns/10ps
module adc_source_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] convChannel,
   input wire logic convStrobe,
   output logic [11:0] adcCode
);
   logic [13:0] odd_r;
   logic [11:0] noise_r;
   // every second conversion of a channel reads one count higher
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         odd_r <= '0;
         noise_r <= 12'h5a5;
      end
      else
      begin
         if (convStrobe && convChannel < 4'he)
            odd_r[convChannel] <= ~odd_r[convChannel];
         noise_r <= noise_r + 12'h3b7;
      end
   end
   // outside a strobe the code is stale, so it keeps moving
   assign adcCode = convStrobe ? {convChannel, 8'h5a} + {11'h000, odd_r[convChannel]} : noise_r;
endmodule : adc_source_model

// file: tb/testbench.sv
// self-checking bench for the acquisition and flex supply block
`timescale 1ns/10ps
`include "flex_pack_map.svh"
module testbench;
   localparam logic [15:0] TW [0:10] = '{16'h1a01, 16'h2b02, 16'h3c03, 16'h4d04, 16'h5e05,
      16'h6f06, 16'h7a07, 16'h8b08, 16'h9c09, 16'had0a, 16'hbe0b};
   localparam logic [7:0] CRC = 8'hc3; // arbitrary
   localparam logic [31:0] DID = 32'h1357_2468; // arbitrary
   logic clk = 0;
   logic rst = 1;
   // host register contents start at their power-on values
   flex_pack_pkg::pack_cfg_t pack_configuration_register = '{1'b1, 1'b1, 4'hf, 4'hf, 4'hf, 1'b0};
   logic [13:0] cell_channel_enables = '0;
   logic pathSel = 0;
   logic acqStart = 0;
   logic faultRaw = 0;
   logic alertRst = 1;
   logic [2:0] ovs = '0;
   logic [3:0] readIndex = '0;
   logic [11:0] adcCode;
   logic [15:0] readData, trimData, idLo, idHi;
   logic [3:0] topCellApplied, blockSourceApplied, convChannel;
   logic flexEnableApplied, blockMuxConnect, topCellDisconnect, convStrobe;
   logic altPathActive, acqBusy, acqDone, supplyMuxFaultAlert;
   int errors = 0;
   int checks_done = 0;
   int seed = 32'h25bb;
   logic [3:0] chanQ [$];
   logic [15:0] res [0:13] = '{default: 16'h0000};

   flex_pack_acquisition_config #(.TRIM_WORD(TW), .TRIM_CRC(CRC), .DEVICE_ID(DID)) u_dut (
      .clk(clk), .rst(rst), .pack_configuration_register(pack_configuration_register), .cellChannelEnables(cell_channel_enables),
      .inputPathSelect(pathSel), .oversampleLog2(ovs), .acqStart(acqStart),
      .adcCode(adcCode), .switchFaultRaw(faultRaw), .alertResetFlag(alertRst),
      .readIndex(readIndex), .readData(readData), .trimData(trimData),
      .identifierLowWord(idLo), .identifierHighWord(idHi), .topCellApplied(topCellApplied),
      .flexEnableApplied(flexEnableApplied), .blockSourceApplied(blockSourceApplied),
      .blockMuxConnect(blockMuxConnect), .topCellDisconnect(topCellDisconnect),
      .convChannel(convChannel), .convStrobe(convStrobe), .altPathActive(altPathActive),
      .acqBusy(acqBusy), .acqDone(acqDone), .supplyMuxFaultAlert(supplyMuxFaultAlert));

   adc_source_model u_adc (.clk(clk), .rst(rst), .convChannel(convChannel),
      .convStrobe(convStrobe), .adcCode(adcCode));

   // free-running 25 MHz clock
   initial
   begin
      forever #20 clk = ~clk;
   end

   task tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick

   task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task wrap_up;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   // each strobe takes the oldest expected channel off the queue
   always @(negedge clk)
   begin
      if (convStrobe === 1'b1)
      begin
         if (chanQ.size() == 0)
            chk(16'(convChannel), 16'hffff, "unexpected conversion");
         else
            chk(16'(convChannel), 16'(chanQ.pop_front()), "channel order");
      end
   end

   // random pack settings, copies made equal half the time
   task cfg_case;
      logic mism;
      logic en;
      logic [3:0] top, blk;
      flex_pack_pkg::pack_cfg_t c;
      c = 14'($random(seed));
      if (c.topCellSelectA[0])
      begin
         c.topCellSelectB = c.topCellSelectA;
         c.flexSupplyEnableB = c.flexSupplyEnableA;
      end
      pack_configuration_register = c;
      tick(2);
      mism = (pack_configuration_register.flexSupplyEnableA != pack_configuration_register.flexSupplyEnableB) ||
         (pack_configuration_register.topCellSelectA != pack_configuration_register.topCellSelectB);
      en = mism | pack_configuration_register.flexSupplyEnableA;
      top = (mism || pack_configuration_register.topCellSelectA < 4'h8) ? 4'hf : pack_configuration_register.topCellSelectA;
      blk = pack_configuration_register.blockDividerSourceSelect < 4'h8 ? 4'hf : pack_configuration_register.blockDividerSourceSelect;
      chk(16'(flexEnableApplied), 16'(en), "flex enable");
      chk(16'(topCellApplied), 16'(top), "top cell");
      chk(16'(blockSourceApplied), 16'(blk), "block source");
      chk(16'(blockMuxConnect), 16'(en && top != 4'hf && blk != 4'hf), "block mux");
   endtask : cfg_case

   // one acquisition; settings land before the start
   task acq(input logic [2:0] n, input logic [13:0] en, input logic p, input logic disc);
      int cnt, k, s, bad;
      cell_channel_enables = en;
      ovs = n;
      pathSel = p;
      for (s = 0; s < (2 << n); s++)
         for (k = 0; k < 14; k++)
            if (en[k])
               chanQ.push_back(k[3:0]);
      acqStart = 1;
      tick(1);
      acqStart = 0;
      pathSel = ~p;
      cnt = 0;
      k = 0;
      bad = 0;
      while (acqDone !== 1'b1 && k < 8000)
      begin
         if (topCellDisconnect === 1'b1)
            cnt++;
         if (acqBusy === 1'b1 && altPathActive !== p)
            bad++;
         tick(1);
         k++;
      end
      if (k == 8000)
      begin
         errors++;
         $display("ERROR %0t acquisition never finished", $time);
         wrap_up;
      end
      chk(16'(chanQ.size()), 16'h0000, "scans run");
      chk(16'(bad), 16'h0000, "path select");
      chk(16'(disc ? cnt >= (2 << n) * `SETTLE_CYCLES : cnt == 0), 16'h0001, "settle");
      for (k = 0; k < 15; k++)
      begin
         if (k < 14 && en[k])
            res[k] = {k[3:0], 8'h5a, 4'h8};
         readIndex = k[3:0];
         tick(2);
         chk(readData, k < 14 ? res[k] : 16'h0000, "result");
      end
      $display("test acquisition n=%0d path=%0d done", n, p);
   endtask : acq

   // main sequence
   initial
   begin
      tick(4);
      chk(16'(flexEnableApplied), 16'h0001, "enable in reset");
      chk(16'(acqBusy), 16'h0000, "idle in reset");
      rst = 0;
      tick(1);
      chk(16'(flexEnableApplied), 16'h0001, "enable default");
      chk(16'(topCellApplied), 16'h000f, "top default");
      chk(16'(blockSourceApplied), 16'h000f, "block default");
      chk(idLo, DID[15:0], "id low");
      chk(idHi, DID[31:16], "id high");
      chk(16'({idHi, idLo} != 32'h0000_0000), 16'h0001, "id nonzero");
      for (int k = 0; k < 16; k++)
      begin
         readIndex = k[3:0];
         tick(2);
         chk(trimData, k < 10 ? TW[k] : k == 10 ? {CRC, TW[10][7:0]} : 16'h0000, "trim");
      end
      $display("test reset and rom done");
      repeat (40) cfg_case;
      $display("test pack config done");
      // no balancing switch is ever closed here, so the top pair never closes together
      pack_configuration_register = '{1'b1, 1'b1, 4'hc, 4'hc, 4'he, 1'b1};
      acq(3'h0, 14'h3fff, 1'b0, 1'b0);
      acq(3'h1, 14'($random(seed)) | 14'h0800, 1'b1, 1'b1);
      // channel 0 forced off so its held result is exercised
      acq(3'h2, (14'($random(seed)) | 14'h0800) & 14'h3ffe, 1'b0, 1'b0);
      // full 128-measurement average on a high code
      acq(3'h7, 14'h2000, 1'b0, 1'b0);
      faultRaw = 1;
      tick(3);
      chk(16'(supplyMuxFaultAlert), 16'h0000, "alert gated");
      alertRst = 0;
      tick(3);
      chk(16'(supplyMuxFaultAlert), 16'h0001, "alert raised");
      faultRaw = 0;
      tick(3);
      chk(16'(supplyMuxFaultAlert), 16'h0000, "alert cleared");
      $display("test alert done");
      wrap_up;
   end
endmodule : testbench
